// file: shared/aor_cfg.svh
// Constants for the converter output code and range flag block
`ifndef AOR_CFG_SVH
`define AOR_CFG_SVH

`define AOR_CODE_W      14
`define AOR_CODE_MID    14'h2000
`define AOR_CODE_ZERO   14'h0000
`define AOR_CODE_FULL   14'h3fff
`define AOR_LATENCY     3
`define AOR_CLK_NS      25
`define AOR_BUF_DEPTH   2

`endif

// file: shared/aor_pkg.sv
// Types for the converter output code and range flag block
package aor_pkg;
    // Sample word with its range flag, carried together through the pipe
    typedef struct packed {
        logic [13:0] code;
        logic        range_exceeded_flag;
    } aor_sample_s;
    // Where a sample lies against the converter's span
    typedef enum logic [1:0] {
        AOR_IN_SPAN,
        AOR_UNDER,
        AOR_OVER
    } aor_span_e;
endpackage

// file: hdl/aor_output.sv
// Output code formatting, range flag and output buffer of the converter
`timescale 1ns/1ps
`default_nettype none
`include "aor_cfg.svh"

module aor_output
    import aor_pkg::*;
#(
    parameter int LATENCY = `AOR_LATENCY
) (
    input  wire logic                       mclk,
    input  wire logic                       reset,
    input  wire logic                       sample_clk,
    input  wire logic signed [`AOR_CODE_W:0] diff_sample,
    input  wire logic                       out_ready,
    output logic                            out_valid,
    output aor_sample_s                     out_data,
    output logic                            in_stall
);

    ////////////////////////////////////////////////////////////////////
    // Both sample clock edges: the rise arms a conversion, the fall
    // launches it. Sample clock is taken as synchronous to mclk.
    logic sclk_q, sclk_d;
    logic hold_q, hold_d;
    logic rise, fall;

    always_comb begin
        sclk_d = sample_clk;
        rise   = sample_clk & ~sclk_q;
        fall   = ~sample_clk & sclk_q;
    end

    // A fall with no rise before it starts nothing
    always_comb begin
        hold_d = hold_q;
        if (rise) begin
            hold_d = 1'b1;
        end else if (fall) begin
            hold_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sclk_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
            hold_q <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Code formatting: input is signed LSBs about midscale; the valid
    // span runs from minus full scale to full scale minus one LSB.
    localparam logic signed [`AOR_CODE_W:0] LOW_LIMIT  = -$signed({1'b0, `AOR_CODE_MID});
    localparam logic signed [`AOR_CODE_W:0] HIGH_LIMIT = $signed({1'b0, `AOR_CODE_MID}) - 15'sd1;

    // Minus full scale itself is in span; codes below it clamp low, codes above full scale minus one LSB clamp high
    function automatic aor_span_e classify(input logic signed [`AOR_CODE_W:0] d);
        aor_span_e c;
        c = AOR_IN_SPAN;
        if (d < LOW_LIMIT) begin
            c = AOR_UNDER;
        end else if (d > HIGH_LIMIT) begin
            c = AOR_OVER;
        end
        return c;
    endfunction

    // In span the code is the low bits with the MSB flipped
    function automatic logic [`AOR_CODE_W-1:0] in_span_code(input logic signed [`AOR_CODE_W:0] d);
        return d[`AOR_CODE_W-1:0] ^ `AOR_CODE_MID;
    endfunction

    function automatic aor_sample_s format_sample(input logic signed [`AOR_CODE_W:0] d);
        aor_sample_s s;
        s.code                = in_span_code(d);
        s.range_exceeded_flag = 1'b0;
        unique case (classify(d))
            AOR_UNDER: begin
                s.code                = `AOR_CODE_ZERO;
                s.range_exceeded_flag = 1'b1;
            end
            AOR_OVER: begin
                s.code                = `AOR_CODE_FULL;
                s.range_exceeded_flag = 1'b1;
            end
            AOR_IN_SPAN: begin
                s.range_exceeded_flag = 1'b0;
            end
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pipeline: word and flag move as one struct, one stage per sample.
    // The flag is worked out afresh for each sample, so it drops with
    // the first in-range word and never lags its data.
    aor_sample_s pipe_q    [LATENCY];
    aor_sample_s pipe_d    [LATENCY];
    aor_sample_s stage_in  [LATENCY];
    logic        pv_q      [LATENCY];
    logic        pv_d      [LATENCY];
    logic        stage_vin [LATENCY];
    logic        advance;

    assign advance      = fall & hold_q & ~in_stall;
    assign stage_in[0]  = format_sample(diff_sample);
    assign stage_vin[0] = 1'b1;

    // Every stage loads on the same fall, so a stall freezes them all
    for (genvar g = 0; g < LATENCY; g++) begin : g_stage
        if (g > 0) begin : g_link
            assign stage_in[g]  = pipe_q[g-1];
            assign stage_vin[g] = pv_q[g-1];
        end

        always_comb begin
            pipe_d[g] = pipe_q[g];
            pv_d[g]   = pv_q[g];
            if (advance) begin
                pipe_d[g] = stage_in[g];
                pv_d[g]   = stage_vin[g];
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                pipe_q[g] <= '0;
                pv_q[g]   <= 1'b0;
            end else begin
                pipe_q[g] <= pipe_d[g];
                pv_q[g]   <= pv_d[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Two-entry output buffer; a receiver stall fills it, then the pipe
    // stops advancing. The sample offered during that stall is lost at
    // the input, never a word already converted.
    localparam logic [1:0] BUF_FULL = 2'(`AOR_BUF_DEPTH);
    localparam logic [1:0] ONE_WORD = 2'd1;
    aor_sample_s buf_q    [`AOR_BUF_DEPTH];
    aor_sample_s buf_d    [`AOR_BUF_DEPTH];
    aor_sample_s shift_in [`AOR_BUF_DEPTH];
    logic [1:0]  cnt_q, cnt_d;
    logic [1:0]  fill;
    logic        push, pop;

    assign push      = advance & pv_q[LATENCY-1];
    assign pop       = out_valid & out_ready;
    assign in_stall  = (cnt_q == BUF_FULL) & ~out_ready;
    assign out_valid = cnt_q != 2'd0;
    assign out_data  = buf_q[0];

    // Count after the pop decides which entry a pushed word lands in
    always_comb begin
        fill = cnt_q;
        if (pop) begin
            fill = cnt_q - ONE_WORD;
        end
        cnt_d = fill;
        if (push) begin
            cnt_d = fill + ONE_WORD;
        end
    end

    // Last entry keeps its word on a pop; it is dead until refilled
    for (genvar e = 0; e < `AOR_BUF_DEPTH; e++) begin : g_entry
        if (e + 1 < `AOR_BUF_DEPTH) begin : g_shift
            assign shift_in[e] = buf_q[e+1];
        end else begin : g_last
            assign shift_in[e] = buf_q[e];
        end

        always_comb begin
            buf_d[e] = buf_q[e];
            if (pop) begin
                buf_d[e] = shift_in[e];
            end
            if (push && fill == 2'(e)) begin
                buf_d[e] = pipe_q[LATENCY-1];
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                buf_q[e] <= '0;
            end else begin
                buf_q[e] <= buf_d[e];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q <= 2'd0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule
`default_nettype wire

// file: verif/aor_output_asserts.sv
// Checker for the output code and range flag block
`timescale 1ns/1ps
`default_nettype none
module aor_output_asserts
    import aor_pkg::*;
#(parameter int LATENCY = 3) (
    input wire logic               mclk,
    input wire logic               reset,
    input wire logic               sample_clk,
    input wire logic signed [14:0] diff_sample,
    input wire logic               out_ready,
    input wire logic               out_valid,
    input wire aor_sample_s        out_data,
    input wire logic               in_stall
);
    wire logic        f = out_data.range_exceeded_flag;
    wire logic [13:0] c = out_data.code;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_under_clamp: assert property (f && !c[13] |-> c == 14'h0000) else $error("under");
    chk_over_clamp: assert property (f && c[13] |-> c == 14'h3fff) else $error("over");
    chk_word_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("hold");
    chk_stall_full: assert property (in_stall |-> out_valid && !out_ready) else $error("stall");
    chk_flag_paired: assert property ($changed(f) && $past(out_valid) |-> $past(out_ready)) else $error("flag");
    chk_valid_drop: assert property ($fell(out_valid) |-> $past(out_ready)) else $error("drop");
    chk_rise_on_fall: assert property ($rose(out_valid) |-> $past(sample_clk, 2) && !$past(sample_clk)) else $error("rise");
    chk_idle_release: assert property ($fell(reset) |-> !out_valid && !in_stall) else $error("idle");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind aor_output aor_output_asserts #(.LATENCY(LATENCY)) u_chk (.mclk, .reset, .sample_clk, .diff_sample,
    .out_ready, .out_valid, .out_data, .in_stall);
`default_nettype wire

// file: verif/aor_host.sv
// Host model that decodes samples and stalls at random in half of each 128 cycles
`timescale 1ns/1ps
`default_nettype none
module aor_host
    import aor_pkg::*;
(
    input  wire logic        mclk,
    input  wire aor_sample_s out_data,
    output logic             out_ready
);
    integer     seed = 32'h7423bdd1;
    logic [6:0] cnt  = 7'h00;
    wire logic [1:0] range_class = {2{out_data.range_exceeded_flag}} & {out_data.code[13], !out_data.code[13]};
    wire logic [13:0] twos_code  = {!out_data.code[13], out_data.code[12:0]};
    initial out_ready = 1'b0;
    // Random stalls in half of each 128 cycles, so the buffer fills and refuses
    always @(posedge mclk) begin
        #1;
        cnt = cnt + 7'h01;
        out_ready = cnt[6] | 1'($random(seed));
    end
endmodule
`default_nettype wire

// file: verif/aor_output_tb.sv
// Self-checking bench for the output code and range flag block
`timescale 1ns/1ps
`default_nettype none
module aor_output_tb import aor_pkg::*; ;
    logic mclk = 0, reset = 1, sample_clk = 0, prev = 0, out_ready, out_valid, in_stall;
    logic signed [14:0] diff_sample = 0;
    aor_sample_s        out_data;
    aor_sample_s        exp_q[$];
    integer             seed = 32'h7423bdd1, error_cnt = 0, n_checks = 0, i;
    integer             m_buf = 0, m_pipe = 0;
    logic               m_stall, m_pop;
    int                 v[5] = '{-8193, -8192, 0, 8191, 8192};
    aor_output #(.LATENCY(3)) DUT (.mclk, .reset, .sample_clk, .diff_sample, .out_ready, .out_valid,
        .out_data, .in_stall);
    aor_host host (.mclk, .out_data, .out_ready);
    function automatic aor_sample_s expect_word(int d);
        if (d < -8192) return '{14'h0000, 1'b1};
        if (d > 8191) return '{14'h3fff, 1'b1};
        return '{14'(d + 8192), 1'b0};
    endfunction
    task automatic check_word(aor_sample_s got, aor_sample_s exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(logic got, logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge mclk) if (!reset) begin
        m_stall = m_buf == 2 && !out_ready;
        m_pop   = m_buf > 0 && out_ready;
        check_flag(in_stall, m_stall);
        check_flag(out_valid, m_buf > 0);
        if (m_pop) begin
            check_word(out_data, exp_q.pop_front());
            m_buf--;
        end
        if (prev && !sample_clk && !m_stall) begin
            exp_q.push_back(expect_word(diff_sample));
            if (m_pipe == 3) m_buf++;
            else m_pipe++;
        end
        prev <= sample_clk;
    end
    initial forever #12.5 mclk = ~mclk;
    initial begin
        repeat (5) @(posedge mclk);
        #1 reset = 0;
        // Boundary codes first, then random values spilling past both ends
        for (i = 0; i < 400; i++) begin
            diff_sample = 15'(i < 5 ? v[i] : $random(seed) % 9000);
            sample_clk = 1;
            repeat (2) @(posedge mclk);
            #1 sample_clk = 0;
            repeat (2) @(posedge mclk);
            #1;
        end
        repeat (200) @(posedge mclk);
        give_verdict();
    end
    initial begin
        #(25 * 3000);
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
